// File: rtl/mmst_bkpt.v
// Breakpoint arming and trap qualification.
// Assumes raw address compares arrive from the breakpoint comparators.
`include "mmst_defines.vh"
module mmst_bkpt (
  input wire core_clk, // System clock
  input wire resetn, // Synchronous reset, active low
  input wire status_write, // Status register written
  input wire enable, // Breakpoint enable bit
  input wire user_only, // User-only breakpoint bit
  input wire user_mode, // CPU in user mode
  input wire access_valid, // CPU access this cycle
  input wire [2:0] cpu_status, // Low CPU status bits
  input wire hit_first, // First register compare match
  input wire hit_second, // Second register compare match
  output wire trap, // Breakpoint trap this cycle
  output wire trap_second // Trap came from second register
);
  reg [1:0] fetch_count; // Non-sequential fetches since write
  wire armed;
  wire qualified;

  // Any status write disarms, so a return path cannot false-trigger
  always @(posedge core_clk)
  begin
    if (!resetn)
      fetch_count <= 2'h0;
    else if (status_write)
      fetch_count <= 2'h0;
    else if (access_valid && cpu_status == `MMST_ST_NSEQ && !armed)
      fetch_count <= fetch_count + 2'h1;
  end

  assign armed = enable && fetch_count == `MMST_ARM_FETCHES;
  // Sequential fetch never trips a break directly
  assign qualified = armed && access_valid && cpu_status != `MMST_ST_SEQ
    && (!user_only || user_mode);
  assign trap = qualified && (hit_first || hit_second);
  assign trap_second = hit_second;
endmodule

// File: rtl/mmst_defines.vh
// Constants for the memory management status register and translation buffer.
// Assumes one synchronous clock domain shared with the host CPU.
`ifndef MMST_DEFINES_VH
`define MMST_DEFINES_VH
// Register select codes on the slave instruction short field
`define MMST_SEL_STATUS 4'hA
`define MMST_SEL_BASE_FIRST 4'hC
`define MMST_SEL_BASE_SECOND 4'hD
`define MMST_SEL_PURGE 4'hF
// Status/control register bit positions
`define MMST_B_TE 0
`define MMST_B_CLR 1
`define MMST_B_BRK 2
`define MMST_F_KIND 5:3
`define MMST_B_ED 6
`define MMST_B_BN 7
`define MMST_F_EST 10:8
`define MMST_B_BD 11
`define MMST_F_BST 14:12
`define MMST_B_TU 16
`define MMST_B_TS 17
`define MMST_B_DS 18
`define MMST_B_AO 19
`define MMST_B_BEN 20
`define MMST_B_UB 21
`define MMST_B_AI 22
// Error kind bit values
`define MMST_KIND_PL 3'h1
`define MMST_KIND_IL1 3'h2
`define MMST_KIND_IL2 3'h4
// CPU status codes (low three bits)
`define MMST_ST_SEQ 3'h0
`define MMST_ST_NSEQ 3'h1
`define MMST_ST_RMW 3'h3
// Fetches needed before breakpoints arm
`define MMST_ARM_FETCHES 2'h2
// Sequencer states
`define MMST_S_IDLE 1'h0
`define MMST_S_WALK 1'h1
`endif

// File: rtl/mmst_tlb.v
// Fully associative translation buffer with true LRU replacement.
// Assumes the caller holds lookup inputs stable through a fill.
module mmst_tlb #(
  parameter ENTRIES = 32,
  parameter AW = 5
) (
  input wire core_clk, // System clock
  input wire resetn, // Synchronous reset, active low
  input wire [14:0] lk_vpn, // Virtual page number looked up
  input wire lk_space, // Space qualifier looked up
  output reg lk_hit, // Tag match found
  output reg [15:0] lk_frame, // Matching translation
  output reg lk_mod, // Matching modified bit
  output reg [1:0] lk_pl, // Matching net protection
  input wire touch, // Mark matching entry most recent
  input wire fill, // Load a new entry
  input wire [15:0] fill_frame, // New translation
  input wire fill_mod, // New modified bit
  input wire [1:0] fill_pl, // New net protection
  input wire purge_one, // Purge entry matching purge tag
  input wire [14:0] purge_vpn, // Purge page number
  input wire purge_space_one, // Purge tag space qualifier
  input wire purge_all, // Purge whole address space
  input wire purge_space // Space for whole purge
);
  localparam [31:0] OLDEST_W = ENTRIES - 1; // Oldest age at full width
  localparam [AW-1:0] OLDEST = OLDEST_W[AW-1:0]; // Cut to the age width
  reg [14:0] tag_vpn [0:ENTRIES-1]; // Page number tags
  reg [ENTRIES-1:0] tag_space; // Space qualifier tags
  reg [ENTRIES-1:0] full; // Entry holds a mapping
  reg [15:0] frame [0:ENTRIES-1]; // Translations
  reg [ENTRIES-1:0] mod; // Modified bits
  reg [1:0] pl [0:ENTRIES-1]; // Net protection levels
  reg [AW-1:0] age [0:ENTRIES-1]; // Zero is most recent
  reg [AW-1:0] hit_idx; // Matching entry
  reg [AW-1:0] victim; // Fill recipient
  reg have_empty; // An empty entry exists
  integer i; // Compare loop index
  integer j; // Storage loop index, kept apart from the compare loop

  // Associative compare across all entries
  always @*
  begin
    lk_hit = 1'b0;
    hit_idx = {AW{1'b0}};
    lk_frame = 16'h0000;
    lk_mod = 1'b0;
    lk_pl = 2'h0;
    victim = {AW{1'b0}};
    have_empty = 1'b0;
    for (i = 0; i < ENTRIES; i = i + 1)
    begin
      if (full[i] && tag_vpn[i] == lk_vpn && tag_space[i] == lk_space)
      begin
        lk_hit = 1'b1;
        hit_idx = i[AW-1:0];
        lk_frame = frame[i];
        lk_mod = mod[i];
        lk_pl = pl[i];
      end
      // Empty slots beat the oldest; saves evicting live mappings
      if (!full[i] && !have_empty)
      begin
        have_empty = 1'b1;
        victim = i[AW-1:0];
      end
      else if (!have_empty && age[i] == OLDEST)
        victim = i[AW-1:0];
    end
    // A modified-bit refill rewrites the matching entry, never a twin
    if (lk_hit)
      victim = hit_idx;
  end

  // Entry storage, purges and age bookkeeping
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      full <= {ENTRIES{1'b0}};
      for (j = 0; j < ENTRIES; j = j + 1)
        age[j] <= j[AW-1:0];
    end
    else
    begin
      for (j = 0; j < ENTRIES; j = j + 1)
      begin
        if (purge_all && tag_space[j] == purge_space)
          full[j] <= 1'b0;
        if (purge_one && tag_vpn[j] == purge_vpn && tag_space[j] == purge_space_one)
          full[j] <= 1'b0;
      end
      if (fill)
      begin
        tag_vpn[victim] <= lk_vpn;
        tag_space[victim] <= lk_space;
        frame[victim] <= fill_frame;
        mod[victim] <= fill_mod;
        pl[victim] <= fill_pl;
        full[victim] <= 1'b1;
      end
      // Ages stay a permutation, so exactly one entry is oldest
      if (fill || (touch && lk_hit))
        for (j = 0; j < ENTRIES; j = j + 1)
          if (j[AW-1:0] == (fill ? victim : hit_idx))
            age[j] <= {AW{1'b0}};
          else if (age[j] < age[fill ? victim : hit_idx])
            age[j] <= age[j] + 1'b1;
    end
  end
endmodule

// File: rtl/mmst_top.v
// Status/control register, translation sequencing and buffer control.
// Assumes the CPU holds an access until translated or aborted, and an
// external walker returns page table entries for each walk request.
`include "mmst_defines.vh"
module mmst_top (
  input wire core_clk, // System clock, 10 MHz
  input wire resetn, // Synchronous reset, active low
  input wire register_load_instr, // Register load strobe
  input wire register_store_instr, // Register store strobe
  input wire [3:0] reg_sel, // Register short-field code
  input wire [31:0] reg_wdata, // Load data
  output reg [31:0] reg_rdata, // Store data
  input wire va_valid, // Virtual address presented
  input wire [23:0] va, // Virtual address
  input wire user_mode, // CPU user mode
  input wire data_direction_input, // High for write
  input wire [2:0] cpu_status, // Low CPU status bits
  input wire bp_hit_first, // First breakpoint compare
  input wire bp_hit_second, // Second breakpoint compare
  output reg pa_valid, // Physical address ready
  output reg [24:0] pa, // Physical address
  output reg abort_pulse, // Abort to CPU
  output reg int_pulse, // Breakpoint interrupt
  output reg walk_req, // Start page table walk
  output reg [23:0] walk_va, // Address to walk
  output reg walk_space, // Walk uses second base
  input wire walk_done, // Walk entries returned
  input wire walk_l1_valid, // First level valid
  input wire walk_l2_valid, // Second level valid
  input wire [1:0] walk_l1_pl, // First level protection
  input wire [1:0] walk_l2_pl, // Second level protection
  input wire [15:0] walk_frame, // Memory bit and frame
  input wire walk_mod // Second level modified bit
);
  // Control bits
  reg user_xlate_enable;
  reg supervisor_xlate_enable;
  reg dual_mapping_select;
  reg privilege_override;
  reg breakpoint_enable;
  reg user_only_breakpoint;
  reg abort_select;
  // Status fields
  reg xlate_error_flag;
  reg break_flag;
  reg [2:0] xlate_error_kind;
  reg error_direction;
  reg breakpoint_number;
  reg [2:0] error_cpu_status;
  reg break_direction;
  reg [2:0] break_cpu_status;
  reg [23:0] page_table_base_first; // Stored only; walker owns use
  reg [23:0] page_table_base_second;
  reg state;
  reg walk_user; // Mode captured at walk start
  reg walk_write;
  reg [2:0] walk_status;

  wire write_cycle = data_direction_input;
  wire status_write = register_load_instr && reg_sel == `MMST_SEL_STATUS;
  wire clear_status = status_write && reg_wdata[`MMST_B_CLR];
  wire xlate_on = user_mode ? user_xlate_enable : supervisor_xlate_enable;
  wire space_q = dual_mapping_select && user_mode;
  wire [1:0] level_now;
  wire [1:0] level_walk;
  wire tlb_hit;
  wire [15:0] tlb_frame;
  wire tlb_mod;
  wire [1:0] tlb_pl;
  wire bp_trap;
  wire bp_second;
  wire idle_access = state == `MMST_S_IDLE && va_valid;
  wire lk_space = state == `MMST_S_WALK ? walk_space : space_q;
  wire [14:0] lk_vpn = state == `MMST_S_WALK ? walk_va[23:9] : va[23:9];
  wire hit_bad;
  wire hit_ok;
  wire walk_ok;
  wire [2:0] walk_kind;
  wire err_hit;
  wire err_walk;
  wire [1:0] net_pl;

  // Access level: high bit user without override, low bit write or rmw
  function [1:0] access_level;
    input user;
    input wr;
    input [2:0] st;
    input ovr;
    begin
      access_level = {user && !ovr, wr || st == `MMST_ST_RMW};
    end
  endfunction

  // Protection forbids when access level exceeds the entry level
  function pl_forbids;
    input [1:0] lvl;
    input [1:0] ent;
    begin
      pl_forbids = lvl > ent;
    end
  endfunction

  assign level_now = access_level(user_mode, write_cycle, cpu_status, privilege_override);
  assign level_walk = access_level(walk_user, walk_write, walk_status, privilege_override);
  assign hit_bad = pl_forbids(level_now, tlb_pl);
  // Write to an unmodified page must walk so memory gets its M bit
  assign hit_ok = tlb_hit && !hit_bad && !(write_cycle && !tlb_mod);
  assign err_hit = idle_access && xlate_on && tlb_hit && hit_bad;
  assign walk_kind = {!walk_l2_valid, !walk_l1_valid,
    pl_forbids(level_walk, walk_l1_pl) || pl_forbids(level_walk, walk_l2_pl)};
  assign walk_ok = walk_kind == 3'h0;
  assign err_walk = state == `MMST_S_WALK && walk_done && !walk_ok;
  assign net_pl = walk_l1_pl < walk_l2_pl ? walk_l1_pl : walk_l2_pl;

  mmst_tlb #(.ENTRIES(32), .AW(5)) u_tlb (
    .core_clk(core_clk),
    .resetn(resetn),
    .lk_vpn(lk_vpn),
    .lk_space(lk_space),
    .lk_hit(tlb_hit),
    .lk_frame(tlb_frame),
    .lk_mod(tlb_mod),
    .lk_pl(tlb_pl),
    .touch(idle_access && xlate_on),
    .fill(state == `MMST_S_WALK && walk_done && walk_ok),
    .fill_frame(walk_frame),
    .fill_mod(walk_mod || walk_write),
    .fill_pl(net_pl),
    .purge_one(register_load_instr && reg_sel == `MMST_SEL_PURGE),
    .purge_vpn(reg_wdata[23:9]),
    .purge_space_one(reg_wdata[31]),
    .purge_all(register_load_instr && (reg_sel == `MMST_SEL_BASE_FIRST ||
      reg_sel == `MMST_SEL_BASE_SECOND)),
    .purge_space(reg_sel == `MMST_SEL_BASE_SECOND)
  );

  mmst_bkpt u_bkpt (
    .core_clk(core_clk),
    .resetn(resetn),
    .status_write(status_write),
    .enable(breakpoint_enable),
    .user_only(user_only_breakpoint),
    .user_mode(user_mode),
    .access_valid(va_valid),
    .cpu_status(cpu_status),
    .hit_first(bp_hit_first),
    .hit_second(bp_hit_second),
    .trap(bp_trap),
    .trap_second(bp_second)
  );

  // Translation sequencer: echo, hit, or walk
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      state <= `MMST_S_IDLE;
      pa_valid <= 1'b0;
      pa <= 25'h0000000;
      walk_req <= 1'b0;
      walk_va <= 24'h000000;
      walk_space <= 1'b0;
      walk_user <= 1'b0;
      walk_write <= 1'b0;
      walk_status <= 3'h0;
    end
    else
    begin
      pa_valid <= 1'b0;
      walk_req <= 1'b0;
      case (state)
        `MMST_S_IDLE:
        begin
          if (va_valid && !xlate_on)
          begin
            pa_valid <= 1'b1;
            pa <= {1'b0, va};
          end
          else if (va_valid && hit_ok)
          begin
            pa_valid <= 1'b1;
            pa <= {tlb_frame, va[8:0]};
          end
          else if (va_valid && !(tlb_hit && hit_bad))
          begin
            // Miss or modified-bit update
            state <= `MMST_S_WALK;
            walk_req <= 1'b1;
            walk_va <= va;
            walk_space <= space_q;
            walk_user <= user_mode;
            walk_write <= write_cycle;
            walk_status <= cpu_status;
          end
        end
        `MMST_S_WALK:
        begin
          if (walk_done)
          begin
            state <= `MMST_S_IDLE;
            pa_valid <= walk_ok;
            pa <= {walk_frame, walk_va[8:0]};
          end
        end
        default:
          state <= `MMST_S_IDLE;
      endcase
    end
  end

  // Abort and interrupt pulses, one cycle each
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      abort_pulse <= 1'b0;
      int_pulse <= 1'b0;
    end
    else
    begin
      abort_pulse <= err_hit || err_walk || (bp_trap && abort_select);
      int_pulse <= bp_trap && !abort_select;
    end
  end

  // Control bits; a hardware trap or error clears breakpoint enable, overriding a software set
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      user_xlate_enable <= 1'b0;
      supervisor_xlate_enable <= 1'b0;
      dual_mapping_select <= 1'b0;
      privilege_override <= 1'b0;
      breakpoint_enable <= 1'b0;
      user_only_breakpoint <= 1'b0;
      abort_select <= 1'b0;
      page_table_base_first <= 24'h000000;
      page_table_base_second <= 24'h000000;
    end
    else
    begin
      if (status_write)
      begin
        user_xlate_enable <= reg_wdata[`MMST_B_TU];
        supervisor_xlate_enable <= reg_wdata[`MMST_B_TS];
        dual_mapping_select <= reg_wdata[`MMST_B_DS];
        privilege_override <= reg_wdata[`MMST_B_AO];
        breakpoint_enable <= reg_wdata[`MMST_B_BEN];
        user_only_breakpoint <= reg_wdata[`MMST_B_UB];
        abort_select <= reg_wdata[`MMST_B_AI];
      end
      if (bp_trap || err_hit || err_walk)
        breakpoint_enable <= 1'b0;
      if (register_load_instr && reg_sel == `MMST_SEL_BASE_FIRST)
        page_table_base_first <= reg_wdata[23:0];
      if (register_load_instr && reg_sel == `MMST_SEL_BASE_SECOND)
        page_table_base_second <= reg_wdata[23:0];
    end
  end

  // Status fields: clear first, so a same-cycle event still lands
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      xlate_error_flag <= 1'b0;
      break_flag <= 1'b0;
      xlate_error_kind <= 3'h0;
      error_direction <= 1'b0;
      breakpoint_number <= 1'b0;
      error_cpu_status <= 3'h0;
      break_direction <= 1'b0;
      break_cpu_status <= 3'h0;
    end
    else
    begin
      if (clear_status)
      begin
        xlate_error_flag <= 1'b0;
        break_flag <= 1'b0;
        xlate_error_kind <= 3'h0;
        error_direction <= 1'b0;
        error_cpu_status <= 3'h0;
        break_direction <= 1'b0;
        break_cpu_status <= 3'h0;
      end
      if (err_hit)
      begin
        xlate_error_flag <= 1'b1;
        xlate_error_kind <= `MMST_KIND_PL;
        error_direction <= !write_cycle;
        error_cpu_status <= cpu_status;
      end
      else if (err_walk)
      begin
        xlate_error_flag <= 1'b1;
        xlate_error_kind <= walk_kind;
        error_direction <= !walk_write;
        error_cpu_status <= walk_status;
      end
      if (bp_trap)
      begin
        break_flag <= 1'b1;
        breakpoint_number <= bp_second;
        break_direction <= !data_direction_input;
        break_cpu_status <= cpu_status;
      end
    end
  end

  // Store path; the clear bit reads as zero
  always @(posedge core_clk)
  begin
    if (!resetn)
      reg_rdata <= 32'h00000000;
    else if (register_store_instr)
    begin
      reg_rdata <= 32'h00000000;
      case (reg_sel)
        `MMST_SEL_STATUS:
        begin
          reg_rdata[`MMST_B_TE] <= xlate_error_flag;
          reg_rdata[`MMST_B_BRK] <= break_flag;
          reg_rdata[`MMST_F_KIND] <= xlate_error_kind;
          reg_rdata[`MMST_B_ED] <= error_direction;
          reg_rdata[`MMST_B_BN] <= breakpoint_number;
          reg_rdata[`MMST_F_EST] <= error_cpu_status;
          reg_rdata[`MMST_B_BD] <= break_direction;
          reg_rdata[`MMST_F_BST] <= break_cpu_status;
          reg_rdata[`MMST_B_TU] <= user_xlate_enable;
          reg_rdata[`MMST_B_TS] <= supervisor_xlate_enable;
          reg_rdata[`MMST_B_DS] <= dual_mapping_select;
          reg_rdata[`MMST_B_AO] <= privilege_override;
          reg_rdata[`MMST_B_BEN] <= breakpoint_enable;
          reg_rdata[`MMST_B_UB] <= user_only_breakpoint;
          reg_rdata[`MMST_B_AI] <= abort_select;
        end
        `MMST_SEL_BASE_FIRST:
          reg_rdata[23:0] <= page_table_base_first;
        `MMST_SEL_BASE_SECOND:
          reg_rdata[23:0] <= page_table_base_second;
        default:
          reg_rdata <= 32'h00000000;
      endcase
    end
  end
endmodule

// File: verification/mmst_top_assertions.sv
// Port-level checks of the status register and translation sequencing.
// Assumes it is bound into the top module and sees only its ports.
module mmst_top_assertions (
  input wire core_clk, // System clock
  input wire resetn, // Synchronous reset, active low
  input wire register_load_instr, // Register load strobe
  input wire register_store_instr, // Register store strobe
  input wire [3:0] reg_sel, // Register code
  input wire [31:0] reg_wdata, // Load data
  input wire [31:0] reg_rdata, // Store data
  input wire va_valid, // Address presented
  input wire [23:0] va, // Virtual address
  input wire pa_valid, // Physical address ready
  input wire [24:0] pa, // Physical address
  input wire abort_pulse, // Abort
  input wire int_pulse, // Breakpoint interrupt
  input wire walk_req, // Walk start
  input wire [23:0] walk_va, // Walk address
  input wire walk_done, // Walk finished
  input wire walk_l1_valid // First level valid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic xl_off; // Both translate enables are clear
  // Shadow of the enables, since the checker cannot see the register
  always @(posedge core_clk)
  begin
    if (!resetn)
      xl_off <= 1'b1;
    else if (register_load_instr && reg_sel == 4'hA)
      xl_off <= !(reg_wdata[16] | reg_wdata[17]);
  end
  property p_echo;
    va_valid && xl_off |=> pa_valid && pa == {1'b0, $past(va)};
  endproperty
  a_echo: assert property (p_echo) else $error("echo address wrong");
  property p_rst_quiet;
    $rose(resetn) |-> !(pa_valid || abort_pulse || int_pulse || walk_req);
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("output after reset");
  property p_clr_bit;
    register_store_instr && reg_sel == 4'hA |=> reg_rdata[1] == 1'b0;
  endproperty
  a_clr_bit: assert property (p_clr_bit) else $error("clear bit reads set");
  property p_bad_sel;
    register_store_instr && reg_sel == 4'h3 |=> reg_rdata == 32'h00000000;
  endproperty
  a_bad_sel: assert property (p_bad_sel) else $error("unknown code reads data");
  property p_walk_pulse;
    walk_req |=> !walk_req;
  endproperty
  a_walk_pulse: assert property (p_walk_pulse) else $error("walk request too long");
  property p_walk_va;
    walk_req |-> walk_va == $past(va);
  endproperty
  a_walk_va: assert property (p_walk_va) else $error("walk address wrong");
  property p_walk_end;
    walk_done |=> pa_valid || abort_pulse;
  endproperty
  a_walk_end: assert property (p_walk_end) else $error("walk left unanswered");
  property p_walk_bad;
    walk_done && !walk_l1_valid |=> abort_pulse && !pa_valid;
  endproperty
  a_walk_bad: assert property (p_walk_bad) else $error("invalid entry not aborted");
  property p_int_once;
    int_pulse |=> !int_pulse [*3];
  endproperty
  a_int_once: assert property (p_int_once) else $error("interrupt repeated");
endmodule

// File: verification/mmst_walk_model.sv
// Page table walker standing in for the memory side of the translator.
// Assumes one walk at a time; answers alternately fast and slow.
module mmst_walk_model (
  input wire core_clk, // System clock
  input wire resetn, // Synchronous reset, active low
  input wire walk_req, // Walk start pulse
  input wire m_l1v, // First level entry valid for next walk
  input wire m_l2v, // Second level entry valid for next walk
  input wire [1:0] m_pl, // First level protection for next walk
  output logic walk_done, // Walk finished pulse
  output logic walk_l1_valid, // First level valid
  output logic walk_l2_valid, // Second level valid
  output logic [1:0] walk_l1_pl, // First level protection
  output logic [1:0] walk_l2_pl, // Second level protection
  output logic [15:0] walk_frame, // Memory bit and frame
  output logic walk_mod // Second level modified bit
);
  localparam logic [15:0] FRAME = 16'h1234; // Frame handed back by every walk
  logic busy; // Walk in progress
  logic slow; // Next walk takes the long path
  logic [2:0] cnt; // Cycles left before answering
  logic [22:0] bus; // Entry fields as one vector
  logic [22:0] cfg; // Entry fields for the current walk
  assign cfg = {m_l1v, m_l2v, m_pl, 2'h3, FRAME, 1'b0};
  assign {walk_l1_valid, walk_l2_valid, walk_l1_pl, walk_l2_pl, walk_frame, walk_mod} = bus;
  // Fields only mean something in the done cycle; else inverted so stale use shows
  always @(posedge core_clk)
  begin
    walk_done <= 1'b0;
    bus <= ~cfg;
    if (!resetn)
    begin
      busy <= 1'b0;
      slow <= 1'b0;
      cnt <= 3'h0;
    end
    else if (walk_req)
    begin
      busy <= 1'b1;
      cnt <= slow ? 3'h4 : 3'h0;
      slow <= !slow;
    end
    else if (busy && cnt == 3'h0)
    begin
      busy <= 1'b0;
      walk_done <= 1'b1;
      bus <= cfg;
    end
    else if (busy)
      cnt <= cnt - 3'h1;
  end
endmodule

// File: verification/testbench.sv
// Self-checking bench for the status register and translation buffer.
// Assumes the walker model answers every walk request.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [23:0] a; logic u; logic w; logic [2:0] s; logic l1v; logic l2v;
    logic [1:0] pl; logic wk; logic ab; logic [2:0] kind;
  } mmst_row_t;
  logic core_clk = 0, resetn = 0, register_load_instr = 0, register_store_instr = 0;
  logic [3:0] reg_sel = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, st_rd;
  logic va_valid = 0, user_mode = 0, data_direction_input = 0;
  logic bp_hit_first = 0, bp_hit_second = 0, m_l1v = 1, m_l2v = 1;
  logic [23:0] va = 24'h0, walk_va;
  logic [2:0] cpu_status = 3'h0;
  logic [1:0] m_pl = 2'h3, walk_l1_pl, walk_l2_pl;
  logic pa_valid, abort_pulse, int_pulse, walk_req, walk_space, walk_done;
  logic walk_l1_valid, walk_l2_valid, walk_mod;
  logic [24:0] pa;
  logic [15:0] walk_frame;
  logic [27:0] res; // Result flags and address of the last access
  int errors = 0, tests_run = 0, cyc = 0, walks = 0, n0 = 0;
  mmst_row_t rows [8];
  localparam logic [31:0] CTL = 32'h00030002; // Both translates on, status clear
  mmst_top i_dut (.*);
  mmst_walk_model i_walk (.*);
  always #50 core_clk = ~core_clk;
  // Cycle ceiling and walk counter
  always @(posedge core_clk)
  begin
    cyc++;
    if (walk_req)
      walks++;
    if (cyc == 3000)
    begin
      errors++;
      stop_test();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task ld(input logic [3:0] s, input logic [31:0] d);
    @(posedge core_clk);
    register_load_instr <= 1'b1;
    reg_sel <= s;
    reg_wdata <= d;
    @(posedge core_clk);
    register_load_instr <= 1'b0;
  endtask
  task rd(input logic [3:0] s);
    @(posedge core_clk);
    register_store_instr <= 1'b1;
    reg_sel <= s;
    @(posedge core_clk);
    register_store_instr <= 1'b0;
    #1 st_rd = reg_rdata;
  endtask
  // Holds the access until the walk ends when a walk is expected
  task acc(input logic [23:0] a, input logic u, w, input logic [2:0] s, input logic wk);
    int n;
    n = 0;
    @(posedge core_clk);
    va_valid <= 1'b1;
    va <= a;
    user_mode <= u;
    data_direction_input <= w;
    cpu_status <= s;
    @(posedge core_clk);
    while (wk && !walk_done && n < 30)
    begin
      @(posedge core_clk);
      n++;
    end
    va_valid <= 1'b0;
    #1 res = {pa_valid, abort_pulse, int_pulse, pa};
  endtask
  task stop_test;
    $display("checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    rows = '{'{24'h000200, 0, 0, 2, 1, 1, 3, 1, 0, 0}, '{24'h000200, 0, 0, 2, 1, 1, 3, 0, 0, 0},
      '{24'h000200, 0, 1, 2, 1, 1, 3, 1, 0, 0}, '{24'h000200, 0, 1, 2, 1, 1, 3, 0, 0, 0},
      '{24'h000400, 0, 0, 1, 0, 1, 3, 1, 1, 2}, '{24'h000600, 0, 1, 3, 1, 0, 3, 1, 1, 4},
      '{24'h000800, 1, 0, 2, 1, 1, 0, 1, 1, 1}, '{24'h000A00, 1, 0, 4, 0, 1, 0, 1, 1, 3}};
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    rd(4'hA);
    chk(st_rd, 32'h0);
    ld(4'hA, 32'h00007FFD);
    rd(4'hA);
    chk(st_rd, 32'h0);
    rd(4'h3);
    chk(st_rd, 32'h0);
    $display("done: reset and access");
    // Each row: clear status, walk or hit, then compare result and status
    foreach (rows[i])
    begin
      ld(4'hA, CTL);
      m_l1v <= rows[i].l1v;
      m_l2v <= rows[i].l2v;
      m_pl <= rows[i].pl;
      acc(rows[i].a, rows[i].u, rows[i].w, rows[i].s, rows[i].wk);
      chk(res[27:25], {!rows[i].ab, rows[i].ab, 1'b0});
      if (!rows[i].ab)
        chk(res[24:0], {16'h1234, rows[i].a[8:0]});
      rd(4'hA);
      chk(st_rd[14:0], rows[i].ab ? {4'h0, rows[i].s, 1'b0, !rows[i].w, rows[i].kind, 3'h1}
        : 15'h0);
    end
    $display("done: translation rows");
    m_l1v <= 1'b1;
    m_l2v <= 1'b1;
    m_pl <= 2'h3;
    ld(4'hA, 32'h0);
    n0 = walks;
    acc(24'hABCDEF, 0, 0, 3'h2, 0);
    chk(res, {3'h4, 1'b0, 24'hABCDEF});
    ld(4'hA, CTL);
    acc(24'h000200, 0, 0, 3'h2, 0);
    chk(res, {3'h4, 16'h1234, 9'h000});
    chk(walks, n0);
    ld(4'hF, 32'h00000200);
    acc(24'h000200, 0, 0, 3'h2, 1);
    chk(walks, n0 + 1);
    ld(4'hC, 32'h0);
    acc(24'h000200, 0, 0, 3'h2, 1);
    chk(walks, n0 + 2);
    $display("done: purge");
    // Both compares hit: two fetches arm, the third traps as interrupt
    ld(4'hA, CTL | 32'h00100000);
    bp_hit_first <= 1'b1;
    bp_hit_second <= 1'b1;
    repeat (2)
    begin
      acc(24'h000200, 0, 0, 3'h1, 0);
      chk(res[26:25], 2'h0);
    end
    acc(24'h000200, 0, 0, 3'h1, 0);
    chk(res[26:25], 2'h1);
    rd(4'hA);
    chk(st_rd & 32'h007FFFFD, 32'h00031884);
    // Abort mode, second compare only; sequential fetch must not trap
    ld(4'hA, CTL | 32'h00500000);
    bp_hit_first <= 1'b0;
    repeat (2) acc(24'h000200, 0, 0, 3'h1, 0);
    acc(24'h000200, 0, 0, 3'h0, 0);
    chk(res[26:25], 2'h0);
    acc(24'h000200, 0, 0, 3'h2, 0);
    chk(res[26:25], 2'h2);
    rd(4'hA);
    chk(st_rd & 32'h007FFFFD, 32'h00432884);
    $display("done: breakpoints");
    // Dual mapping gives user its own space; override lifts its level
    m_pl <= 2'h0;
    ld(4'hA, 32'h000F0002);
    acc(24'h000200, 1, 0, 3'h2, 1);
    chk(res[27:25], 3'h4);
    chk(walk_space, 1'b1);
    // User-only: supervisor hit ignored, user hit traps
    ld(4'hA, CTL | 32'h00300000);
    repeat (2) acc(24'h000200, 0, 0, 3'h1, 0);
    acc(24'h000200, 0, 0, 3'h2, 0);
    chk(res[26:25], 2'h0);
    acc(24'h000200, 1, 0, 3'h2, 0);
    chk(res[26:25], 2'h1);
    $display("done: modes");
    // Mid-run reset clears enables, flags and breakpoint number
    @(posedge core_clk);
    resetn <= 1'b0;
    @(posedge core_clk);
    resetn <= 1'b1;
    rd(4'hA);
    chk(st_rd, 32'h0);
    $display("done: second reset");
    stop_test();
  end
endmodule
bind mmst_top mmst_top_assertions u_chk (.*);
